// file: rtl/pgate_cell.sv
// One clock gate cell for a single peripheral instance.
// Assumes a latch-free flop-based enable; the gated clock is built downstream.
`timescale 1ns/1ps
`default_nettype none

module pgate_cell (
  input  wire logic clk_in,     // Instruction clock
  input  wire logic rst_in,     // Synchronous reset, active high
  input  wire logic gate_in,    // Disable bit from the register
  input  wire logic present_in, // Instance exists in this variant
  output logic      run_out     // Clock enable to the instance
);

  // Enable follows the bit one cycle later
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_out <= 1'b0;
    end else begin
      run_out <= present_in & ~gate_in;
    end
  end

endmodule : pgate_cell

`default_nettype wire

// file: rtl/pgate_pkg.sv
// Package for the peripheral clock gating block: offsets, masks, field positions.
// Assumes a single 100 MHz instruction clock and a plain register port.
package pgate_pkg;

  // Register offsets
  localparam logic [15:0] PGATE_SET_A_OFS = 16'h0770;  // Gate set A
  localparam logic [15:0] PGATE_SET_B_OFS = 16'h0772;  // Gate set B

  // Values after reset
  localparam logic [15:0] PGATE_RESET_VAL = 16'h0000;  // All peripherals enabled

  // Writable bits of set A (bit 8 never exists; bit 2 depends on variant)
  localparam logic [15:0] PGATE_SET_A_MASK = 16'hfeff;  // All but bit 8
  localparam logic [15:0] PGATE_SET_B_MASK = 16'hffff;  // All bits
  localparam int          PGATE_CAN2_BIT   = 2;         // Second CAN gate position

  // Delay from a bit change to the gate moving, in instruction cycles
  localparam int PGATE_GATE_DELAY = 1;                  // One instruction cycle

  // Register port request
  typedef struct packed {
    logic [15:0] addr;   // Byte address
    logic [15:0] wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } pgate_req_t;

endpackage : pgate_pkg

// file: rtl/pgate_top.sv
// Peripheral clock gating: two disable registers and one gate per instance.
// Assumes register port strobes from the same clock; read data one cycle later.
// Function
// - Set bit stops all clocks to peripheral
// - Disabled peripheral ignores register writes
// - Runs only if bit clear and present
// - Both registers read zero after reset
// - Gate off one cycle after set
// - Clocks restored one cycle after clear
// - Unimplemented bits ignore writes, read zero
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module pgate_top #(
  parameter bit HAS_CAN2 = 1'b1  // Variant carries the second CAN
) (
  input  wire logic                clk_in,         // Instruction clock
  input  wire logic                rst_in,         // Synchronous reset
  input  wire pgate_pkg::pgate_req_t req_in,       // Register port request
  output logic [15:0]              rdata_out,      // Read data, cycle after strobe
  output logic [31:0]              run_out,        // Per-instance clock enables
  output logic [31:0]              access_ok_out   // Per-instance register access allowed
);
  import pgate_pkg::*;

  // Bit map of set A, one instance per bit (high = instance stopped)
  //   bit 15 timer 5, bit 14 timer 4, bit 13 timer 3, bit 12 timer 2
  //   bit 11 timer 1, bit 10 quadrature encoder, bit 9 motor PWM
  //   bit 8  absent: never stored, reads zero, never runs
  //   bit 7  I2C, bit 6 UART 2, bit 5 UART 1, bit 4 SPI 2, bit 3 SPI 1
  //   bit 2  second CAN, only on the variant that carries it
  //   bit 1  first CAN, bit 0 ADC
  // Bit map of set B
  //   bits 15..8 input captures 8..1
  //   bits 7..0  output compares 8..1
  // Enable outputs: bit i of run_out is set A bit i for i below 16,
  // and set B bit i-16 above; high means the instance is clocked.

  // Elaboration check: the gate cells give exactly one cycle of delay,
  // so any other figure in the package cannot be served
  if (PGATE_GATE_DELAY != 1) begin : g_bad_delay
    $error("Gate delay must be one cycle");
  end

  // Elaboration check: the second CAN bit must sit inside set A
  if (PGATE_CAN2_BIT < 0 || PGATE_CAN2_BIT > 15) begin : g_bad_can2
    $error("Second CAN bit outside set A");
  end

  // Address match against one register offset, used by both decodes
  function automatic logic pgate_hit(input logic [15:0] addr,
                                     input logic [15:0] ofs);
    return (addr == ofs);
  endfunction : pgate_hit

  // Effective writable mask of set A for this variant
  wire logic [15:0] mask_a = HAS_CAN2 ? PGATE_SET_A_MASK
                           : (PGATE_SET_A_MASK & ~(16'h0001 << PGATE_CAN2_BIT));
  wire logic [15:0] mask_b = PGATE_SET_B_MASK;

  logic [15:0] set_a;  // Gate set A
  logic [15:0] set_b;  // Gate set B

  // Address decode
  wire logic hit_a = pgate_hit(req_in.addr, PGATE_SET_A_OFS);  // Set A selected
  wire logic hit_b = pgate_hit(req_in.addr, PGATE_SET_B_OFS);  // Set B selected
  wire logic [15:0] next_set_a = (req_in.wr && hit_a) ? (req_in.wdata & mask_a) : set_a;
  wire logic [15:0] next_set_b = (req_in.wr && hit_b) ? (req_in.wdata & mask_b) : set_b;
  wire logic [15:0] rd_sel = hit_a ? set_a : (hit_b ? set_b : 16'h0000);

  // Register store
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      set_a <= PGATE_RESET_VAL;
      set_b <= PGATE_RESET_VAL;
    end else begin
      set_a <= next_set_a;
      set_b <= next_set_b;
    end
  end

  // Read data register, zero when no read
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= req_in.rd ? rd_sel : 16'h0000;
    end
  end

  // One gate per instance
  wire logic [31:0] all_bits = {set_b, set_a};
  wire logic [31:0] present  = {mask_b, mask_a};

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : gen_gate
      pgate_cell u_cell (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .gate_in    (all_bits[g]),
        .present_in (present[g]),
        .run_out    (run_out[g])
      );
    end
  endgenerate

  // Register access follows the clock enable
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      access_ok_out <= 32'h0000_0000;
    end else begin
      access_ok_out <= present & ~all_bits;
    end
  end

  // Assertions

  // Named steps of a write to set A and the gate response behind it
  sequence s_write_a;
    req_in.wr && hit_a;
  endsequence

  // Register lands one edge later, enables show it one edge after that; checked on the third edge
  sequence s_gate_a_settles;
    ##3 run_out[15:0] == (mask_a & ~$past(req_in.wdata, 3));
  endsequence

  // Named step of a read that matches neither register offset
  sequence s_read_unmapped;
    req_in.rd && !hit_a && !hit_b;
  endsequence

  // Setting a bit closes the gate on the next edge
  a_gate_follows_bit: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(all_bits[0]) |=> !run_out[0]) else $error("Gate did not close");

  // Clearing a bit reopens the gate on the next edge
  a_gate_reopens: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(all_bits[0]) |=> run_out[0]) else $error("Gate did not reopen");

  // Absent bit of set A never holds a one
  a_bit8_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    set_a[8] == 1'b0) else $error("Unimplemented bit set");

  // Absent instance is never clocked
  a_absent_off: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 !run_out[8]) else $error("Absent peripheral running");

  // A write to set B is stored whole
  a_write_lands: assert property (@(posedge clk_in) disable iff (rst_in)
    req_in.wr && hit_b |=> set_b == $past(req_in.wdata)) else $error("Write lost");

  // A write to set A is stored through the variant mask
  a_write_a_masked: assert property (@(posedge clk_in) disable iff (rst_in)
    s_write_a |=> set_a == ($past(req_in.wdata) & mask_a)) else $error("Set A write wrong");

  // Whole write-to-enable path of set A
  a_gate_a_path: assert property (@(posedge clk_in) disable iff (rst_in)
    s_write_a |-> s_gate_a_settles) else $error("Set A gate path wrong");

  // Read of set A answers in the next cycle
  a_read_data: assert property (@(posedge clk_in) disable iff (rst_in)
    req_in.rd && hit_a |=> rdata_out == $past(set_a)) else $error("Bad read");

  // Read of set B answers in the next cycle
  a_read_b_data: assert property (@(posedge clk_in) disable iff (rst_in)
    req_in.rd && hit_b |=> rdata_out == $past(set_b)) else $error("Bad read of set B");

  // Unmapped reads answer zero
  a_unmapped_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    s_read_unmapped |=> rdata_out == 16'h0000) else $error("Unmapped read not zero");

  // Read data stays zero when no read was asked
  a_idle_read_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    !req_in.rd |=> rdata_out == 16'h0000) else $error("Read data without read");

  // Second CAN bit stays clear on the variant without it
  a_can2_variant: assert property (@(posedge clk_in) disable iff (rst_in)
    HAS_CAN2 || (set_a[PGATE_CAN2_BIT] == 1'b0)) else $error("Absent CAN bit set");

  // Register access follows the clock enable of each instance
  a_access_match: assert property (@(posedge clk_in) disable iff (rst_in)
    access_ok_out == run_out) else $error("Access differs from gate");

  // Reset clears both sets
  a_reset_clear: assert property (@(posedge clk_in)
    rst_in |=> set_a == 16'h0000 && set_b == 16'h0000) else $error("Reset not clear");

  // Reset stops every gate and clears the read data
  a_reset_gates_off: assert property (@(posedge clk_in)
    rst_in |=> run_out == 32'h0000_0000 && rdata_out == 16'h0000)
    else $error("Reset left outputs active");

  // A bit held set keeps the instance stopped
  a_gate_stops: assert property (@(posedge clk_in) disable iff (rst_in)
    all_bits[16] ##1 all_bits[16] |-> !run_out[16]) else $error("Clock not stopped");

endmodule : pgate_top

`default_nettype wire

// file: tb/test_pgate_top.sv
// Bench for peripheral clock gating: random and corner writes, readback, gate timing.
// Assumes the default variant that carries the second CAN gate bit.
`timescale 1ns/1ps
`default_nettype none
module test_pgate_top;
  import pgate_pkg::*;
  logic        clk_in;        // Instruction clock
  logic        rst_in;        // Synchronous reset
  pgate_req_t  req_in;        // Register request
  logic [15:0] rdata_out;     // Read data
  logic [31:0] run_out;       // Clock enables
  logic [31:0] access_ok_out; // Access enables
  logic [15:0] sa;            // Shadow of set A
  logic [15:0] sb;            // Shadow of set B
  logic [15:0] ad;            // Address in use
  logic [15:0] d;             // Data in use
  int          mismatches;    // Failed compares
  int          comparisons;   // All compares
  pgate_top pgate_top_inst (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in),
    .rdata_out(rdata_out), .run_out(run_out), .access_ok_out(access_ok_out));
  // Free-running clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Enables expected from shadows; bit 8 of A is absent
  function automatic logic [31:0] gates(input logic [15:0] a, input logic [15:0] b);
    return ~{b, a} & 32'hfffffeff;
  endfunction : gates
  // One bus cycle driven at the edge; returns 1 ns after that same edge
  task automatic cyc(input logic [15:0] a, input logic [15:0] w, input logic wr, input logic rd);
    @(posedge clk_in);
    req_in <= '{a, w, wr, rd};
    #1;
  endtask : cyc
  // Reset, then both registers and enables at their reset state
  task automatic boot();
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    check(run_out, 32'h0);
    check(access_ok_out, 32'h0);
    sa = 16'h0000;
    sb = 16'h0000;
    cyc(16'h0770, 16'h0000, 1'b0, 1'b1);
    cyc(16'h0772, 16'h0000, 1'b0, 1'b1);
    check(32'(rdata_out), 32'h0);
    check(run_out, gates(sa, sb));
    cyc(16'h0000, 16'h0000, 1'b0, 1'b0);
    check(32'(rdata_out), 32'h0);
  endtask : boot
  // Verdict and end of run
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // Hang guard
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  // Main sequence: all-ones corners, unmapped place, random words, end-of-run reset
  initial begin
    req_in = '0;
    rst_in = 1'b1;
    mismatches = 0;
    comparisons = 0;
    void'($urandom(94725));
    boot();
    for (int i = 0; i < 40; i++) begin
      ad = (i % 3 == 2) ? 16'h0774 : (i[0] ? 16'h0772 : 16'h0770);
      d = (i < 3) ? 16'hffff : 16'($urandom);
      cyc(ad, d, 1'b1, 1'b0);
      cyc(ad, 16'h0000, 1'b0, 1'b1);
      check(run_out, gates(sa, sb));
      if (ad == 16'h0770) sa = d & 16'hfeff;
      if (ad == 16'h0772) sb = d;
      cyc(16'h0000, 16'h0000, 1'b0, 1'b0);
      check(32'(rdata_out), 32'((ad == 16'h0770) ? sa : (ad == 16'h0772) ? sb : 16'h0));
      check(run_out, gates(sa, sb));
      check(access_ok_out, gates(sa, sb));
    end
    boot();
    summarize();
  end
endmodule : test_pgate_top
`default_nettype wire
